// *** rtl/serial_port_pkg.sv ***
// Constants, field layout and small lookup functions for the audio serial port.
// Assumes the core clock (pclk) is the system clock that feeds both dividers.
package serial_port_pkg;

  // Register indexes; byte address is four times the index
  localparam logic [7:0] fmt_ctl_index = 8'h19;
  localparam logic [7:0] div_ctl_index = 8'h1a;
  localparam logic [7:0] fs_ctl_index = 8'h1b;
  localparam logic [7:0] status_index = 8'h1c;

  // Values after reset and writable bits
  localparam logic [15:0] fmt_ctl_reset = 16'h000a;
  localparam logic [15:0] div_ctl_reset = 16'h0004;
  localparam logic [15:0] fs_ctl_reset = 16'h0040;
  localparam logic [15:0] fmt_ctl_mask = 16'h3ddf;
  localparam logic [15:0] div_ctl_mask = 16'h0f1f;
  localparam logic [15:0] fs_ctl_mask = 16'h0fff;

  // Field positions in the format control register
  localparam int pos_play_tdm = 13;
  localparam int pos_play_sel = 12;
  localparam int pos_rec_tdm = 11;
  localparam int pos_rec_sel = 10;
  localparam int pos_hiz = 8;
  localparam int pos_bclk_pol = 7;
  localparam int pos_bclk_dir = 6;
  localparam int pos_fs_pol = 4;
  localparam int pos_width = 2;
  localparam int pos_format = 0;
  // Field positions in the divider and frame sync registers
  localparam int pos_gpio_div = 8;
  localparam int pos_bclk_div = 0;
  localparam int pos_fs_dir = 11;
  localparam int pos_fs_rate = 0;
  // Smallest frame sync rate that the generator accepts
  localparam logic [10:0] fs_rate_min = 11'h008;

  typedef enum logic [1:0] {
    fmt_right = 2'b00,
    fmt_left = 2'b01,
    fmt_i2s = 2'b10,
    fmt_dsp = 2'b11
  } frame_format_t;

  typedef enum logic [0:0] {
    sync_hunt = 1'b0,
    sync_locked = 1'b1
  } sync_state_t;

  // Sample width in bits for each width code
  function automatic logic [5:0] sample_bits(input logic [1:0] code);
    case (code)
      2'h0: sample_bits = 6'h10;
      2'h1: sample_bits = 6'h14;
      2'h2: sample_bits = 6'h18;
      default: sample_bits = 6'h20;
    endcase
  endfunction

  // Bit clock ratio in half steps of the system clock
  function automatic logic [7:0] bclk_half_ratio(input logic [4:0] code);
    case (code)
      5'h00: bclk_half_ratio = 8'h02;
      5'h01: bclk_half_ratio = 8'h03;
      5'h02: bclk_half_ratio = 8'h04;
      5'h03: bclk_half_ratio = 8'h06;
      5'h04: bclk_half_ratio = 8'h08;
      5'h05: bclk_half_ratio = 8'h0a;
      5'h06: bclk_half_ratio = 8'h0b;
      5'h07: bclk_half_ratio = 8'h0c;
      5'h08: bclk_half_ratio = 8'h10;
      5'h09: bclk_half_ratio = 8'h14;
      5'h0a: bclk_half_ratio = 8'h16;
      5'h0b: bclk_half_ratio = 8'h18;
      5'h0c: bclk_half_ratio = 8'h20;
      5'h0d: bclk_half_ratio = 8'h28;
      5'h0e: bclk_half_ratio = 8'h2c;
      5'h0f: bclk_half_ratio = 8'h30;
      5'h10: bclk_half_ratio = 8'h32;
      5'h11: bclk_half_ratio = 8'h3c;
      5'h12: bclk_half_ratio = 8'h40;
      5'h13: bclk_half_ratio = 8'h58;
      5'h14: bclk_half_ratio = 8'h60;
      default: bclk_half_ratio = 8'h00;
    endcase
  endfunction

  // GPIO clock ratio in half steps; zero stops the clock
  function automatic logic [7:0] gpio_half_ratio(input logic [3:0] code);
    case (code)
      4'h0: gpio_half_ratio = 8'h02;
      4'h1: gpio_half_ratio = 8'h04;
      4'h2: gpio_half_ratio = 8'h06;
      4'h3: gpio_half_ratio = 8'h08;
      4'h4: gpio_half_ratio = 8'h0b;
      4'h5: gpio_half_ratio = 8'h0c;
      4'h6: gpio_half_ratio = 8'h10;
      4'h7: gpio_half_ratio = 8'h18;
      4'h8: gpio_half_ratio = 8'h20;
      default: gpio_half_ratio = 8'h00;
    endcase
  endfunction

endpackage

// *** rtl/half_step_divider.sv ***
// Clock divider with half-cycle ratio steps, built on a phase accumulator.
// Assumes ratio changes may glitch one period; nonzero ratios under 2 run at 2.
`timescale 1ns/1ns
module half_step_divider #(
  parameter int RATIO_WIDTH = 8
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Ratio in half steps, zero stops the output low
  input wire logic [RATIO_WIDTH-1:0] half_ratio,
  // Divided clock
  output logic clk_out
);

  typedef struct packed {
    logic [RATIO_WIDTH:0] acc;
    logic clk;
  } div_state_t;

  div_state_t s;
  div_state_t next_s;

  if (RATIO_WIDTH < 7) begin : g_check
    $error("half_step_divider needs RATIO_WIDTH of at least 7");
  end

  // Advance the phase by two half steps each core cycle
  always_comb begin
    logic [RATIO_WIDTH:0] h;
    logic [RATIO_WIDTH:0] sum;
    h = {1'h0, half_ratio};
    sum = s.acc + (RATIO_WIDTH+1)'(2);
    next_s = s;
    if (h < (RATIO_WIDTH+1)'(4)) begin
      h = (RATIO_WIDTH+1)'(4);
    end
    if (half_ratio == '0) begin
      next_s.acc = '0;
      next_s.clk = 1'h0;
    end else begin
      next_s.acc = (sum >= h) ? sum - h : sum;
      next_s.clk = (next_s.acc < (h >> 1));
    end
  end

  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign clk_out = s.clk;

endmodule

// *** rtl/audio_serial_port.sv ***
// Audio serial port: APB register file, bit clock and frame sync generation,
// playback deserialiser and record serialiser for four frame formats.
// Assumes all pin inputs are synchronous to pclk, which is the system clock.
//
// Summary of operation
// - Playback TDM enable moves input to slots
// - Playback slot select picks slot zero or one
// - Record TDM enable makes output slot based
// - Record slot select picks slot zero or one
// - Tristate bit releases every serial pin
// - Bit clock polarity bit inverts bit clock
// - Bit clock direction: input or driven output
// - Frame sync polarity inverts in non-DSP formats
// - DSP mode A: MSB on second edge
// - DSP mode B: MSB on first edge
// - Width code selects 16, 20, 24, 32
// - Format code selects RJ, LJ, I2S, DSP
// - GPIO clock divider from system clock
// - Bit clock divider from system clock
// - Frame sync direction: input or driven output
// - Frame sync is bit clock over rate
//
// Added by the designer: register access over APB.
`timescale 1ns/1ns
module audio_serial_port #(
  parameter int ADDR_WIDTH = 12
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic [ADDR_WIDTH-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Bit clock pin
  input wire logic bclk_in,
  output logic bclk_out,
  output logic bclk_oe_n,
  // Frame sync pin
  input wire logic frame_sync_in,
  output logic frame_sync_out,
  output logic frame_sync_oe_n,
  // Serial data pins
  input wire logic playback_serial_in,
  output logic record_serial_out,
  output logic record_oe_n,
  // GPIO output clock
  output logic gpio_out_clock,
  // Record samples, MSB aligned, taken when record_take pulses
  input wire logic [31:0] record_left,
  input wire logic [31:0] record_right,
  output logic record_take,
  // Playback samples, MSB aligned, valid for one cycle per frame
  output logic [31:0] playback_left,
  output logic [31:0] playback_right,
  output logic playback_valid
);

  typedef struct packed {
    logic [15:0] fmt_ctl;
    logic [15:0] div_ctl;
    logic [15:0] fs_ctl;
    logic [31:0] rdata;
    logic ready;
    logic err;
    logic bclk_pin;
    logic bclk_oe_n;
    logic fs_pin;
    logic fs_oe_n;
    logic rec_bit;
    logic rec_oe_n;
    logic gpio_clk;
    logic eff_prev;
    logic fs_prev;
    logic [10:0] pos;
    logic [10:0] flen;
    serial_port_pkg::sync_state_t sync;
    logic [31:0] play_l_buf;
    logic [31:0] play_r_buf;
    logic [31:0] rec_l_buf;
    logic [31:0] rec_r_buf;
    logic [31:0] play_l;
    logic [31:0] play_r;
    logic play_valid;
    logic rec_take;
  } port_state_t;

  port_state_t s;
  port_state_t next_s;
  logic bclk_div_clk;
  logic gpio_div_clk;

  if (ADDR_WIDTH < 10) begin : g_check
    $error("audio_serial_port needs ADDR_WIDTH of at least 10");
  end

  // Locate a frame position in a channel slot: {hit, channel, bit index}
  function automatic logic [6:0] slot_of(
    input logic [10:0] q,
    input logic [10:0] half,
    input serial_port_pkg::frame_format_t f,
    input logic [5:0] wl,
    input logic mode_b,
    input logic tdm,
    input logic sel
  );
    logic [10:0] w;
    logic [10:0] s0;
    logic [10:0] s1;
    logic [10:0] d0;
    logic [10:0] d1;
    w = {5'h00, wl};
    if (f == serial_port_pkg::fmt_dsp) begin
      s0 = mode_b ? 11'h000 : 11'h001;
      s0 = s0 + ((tdm && sel) ? 11'(w << 1) : 11'h000);
      s1 = s0 + w;
    end else begin
      if (f == serial_port_pkg::fmt_right) begin
        s0 = (half > w) ? half - w : 11'h000;
      end else if (f == serial_port_pkg::fmt_i2s) begin
        s0 = 11'h001;
      end else begin
        s0 = 11'h000;
      end
      s0 = s0 + ((tdm && sel) ? w : 11'h000);
      s1 = half + s0;
    end
    d0 = q - s0;
    d1 = q - s1;
    slot_of = 7'h00;
    // Bits outside the sample width fall in no slot
    if (q >= s0 && d0 < w) begin
      slot_of = {1'h1, 1'h0, d0[4:0]};
    end else if (q >= s1 && d1 < w) begin
      slot_of = {1'h1, 1'h1, d1[4:0]};
    end
  endfunction

  // Bit clock divider
  half_step_divider #(
    .RATIO_WIDTH(8)
  ) u_bclk_div (
    .pclk(pclk),
    .presetn(presetn),
    .half_ratio(serial_port_pkg::bclk_half_ratio(s.div_ctl[4:0])),
    .clk_out(bclk_div_clk)
  );

  // GPIO output clock divider
  half_step_divider #(
    .RATIO_WIDTH(8)
  ) u_gpio_div (
    .pclk(pclk),
    .presetn(presetn),
    .half_ratio(serial_port_pkg::gpio_half_ratio(s.div_ctl[11:8])),
    .clk_out(gpio_div_clk)
  );

  // Register access, clock pins, frame timing and data paths
  always_comb begin
    serial_port_pkg::frame_format_t fmt;
    logic [5:0] wl;
    logic hiz;
    logic bpol;
    logic bdir;
    logic fpol;
    logic fdir;
    logic dsp;
    logic [10:0] rate;
    logic [10:0] len;
    logic [10:0] half;
    logic [10:0] npos;
    logic [10:0] q;
    logic eff;
    logic rise;
    logic fall;
    logic fsn;
    logic start;
    logic [6:0] pslot;
    logic [6:0] rslot;
    logic [4:0] bit_ix;
    logic [31:0] rl;
    logic [31:0] rr;
    logic [7:0] idx;
    logic hit;
    logic setup;
    logic [31:0] rd;
    npos = 11'h000;
    start = 1'h0;
    pslot = 7'h00;
    bit_ix = 5'h00;
    fmt = serial_port_pkg::frame_format_t'(s.fmt_ctl[serial_port_pkg::pos_format +: 2]);
    wl = serial_port_pkg::sample_bits(s.fmt_ctl[serial_port_pkg::pos_width +: 2]);
    hiz = s.fmt_ctl[serial_port_pkg::pos_hiz];
    bpol = s.fmt_ctl[serial_port_pkg::pos_bclk_pol];
    bdir = s.fmt_ctl[serial_port_pkg::pos_bclk_dir];
    fpol = s.fmt_ctl[serial_port_pkg::pos_fs_pol];
    fdir = s.fs_ctl[serial_port_pkg::pos_fs_dir];
    dsp = (fmt == serial_port_pkg::fmt_dsp);
    rate = s.fs_ctl[10:0];
    if (rate < serial_port_pkg::fs_rate_min) begin
      rate = serial_port_pkg::fs_rate_min;
    end
    len = fdir ? rate : s.flen;
    half = len >> 1;
    next_s = s;
    next_s.play_valid = 1'h0;
    next_s.rec_take = 1'h0;

    // APB: decode in setup, answer in the access phase with no wait
    idx = paddr[9:2];
    setup = psel && !penable;
    hit = (paddr[1:0] == 2'h0) && (paddr >> 10 == '0);
    rd = 32'h0000_0000;
    case (idx)
      serial_port_pkg::fmt_ctl_index: rd = {16'h0000, s.fmt_ctl};
      serial_port_pkg::div_ctl_index: rd = {16'h0000, s.div_ctl};
      serial_port_pkg::fs_ctl_index: rd = {16'h0000, s.fs_ctl};
      serial_port_pkg::status_index: rd = {19'h0_0000, s.sync, 1'h0, s.flen};
      default: hit = 1'h0;
    endcase
    next_s.ready = setup;
    next_s.err = setup && !hit;
    next_s.rdata = (setup && hit && !pwrite) ? rd : 32'h0000_0000;
    if (psel && penable && s.ready && pwrite && !s.err) begin
      case (idx)
        serial_port_pkg::fmt_ctl_index:
          next_s.fmt_ctl = pwdata[15:0] & serial_port_pkg::fmt_ctl_mask;
        serial_port_pkg::div_ctl_index:
          next_s.div_ctl = pwdata[15:0] & serial_port_pkg::div_ctl_mask;
        serial_port_pkg::fs_ctl_index:
          next_s.fs_ctl = pwdata[15:0] & serial_port_pkg::fs_ctl_mask;
        default: next_s.fs_ctl = s.fs_ctl;
      endcase
    end

    // Pin drivers and enables
    next_s.bclk_pin = bclk_div_clk ^ bpol;
    next_s.bclk_oe_n = hiz || !bdir;
    next_s.fs_oe_n = hiz || !fdir;
    next_s.gpio_clk = gpio_div_clk;

    // Effective bit clock, with polarity removed
    eff = (bdir ? s.bclk_pin : bclk_in) ^ bpol;
    rise = eff && !s.eff_prev;
    fall = !eff && s.eff_prev;
    next_s.eff_prev = eff;

    // Frame sync as seen by the port; polarity only outside DSP
    fsn = (fdir ? s.fs_pin : frame_sync_in) ^ (fpol && !dsp);
    if (fmt == serial_port_pkg::fmt_i2s) begin
      start = s.fs_prev && !fsn;
    end else begin
      start = !s.fs_prev && fsn;
    end

    // Rising edge: track position, capture playback bit
    if (rise) begin
      next_s.fs_prev = fsn;
      if (start) begin
        npos = 11'h000;
        next_s.flen = s.pos + 11'h001;
        next_s.sync = serial_port_pkg::sync_locked;
        next_s.play_valid = (s.sync == serial_port_pkg::sync_locked);
        next_s.play_l = s.play_l_buf;
        next_s.play_r = s.play_r_buf;
        next_s.play_l_buf = 32'h0000_0000;
        next_s.play_r_buf = 32'h0000_0000;
      end else begin
        npos = (s.pos == 11'h7ff) ? s.pos : s.pos + 11'h001;
      end
      next_s.pos = npos;
      pslot = slot_of(npos, half, fmt, wl, s.fmt_ctl[serial_port_pkg::pos_fs_pol],
        s.fmt_ctl[serial_port_pkg::pos_play_tdm],
        s.fmt_ctl[serial_port_pkg::pos_play_sel]);
      bit_ix = 5'h1f - pslot[4:0];
      if (pslot[6] && !pslot[5]) begin
        next_s.play_l_buf[bit_ix] = playback_serial_in;
      end else if (pslot[6]) begin
        next_s.play_r_buf[bit_ix] = playback_serial_in;
      end
    end

    // Falling edge: next position drives frame sync and record bit
    q = (s.pos + 11'h001 >= len) ? 11'h000 : s.pos + 11'h001;
    rl = s.rec_l_buf;
    rr = s.rec_r_buf;
    if (fall && q == 11'h000) begin
      rl = record_left;
      rr = record_right;
      next_s.rec_l_buf = record_left;
      next_s.rec_r_buf = record_right;
      next_s.rec_take = 1'h1;
    end
    rslot = slot_of(q, half, fmt, wl, s.fmt_ctl[serial_port_pkg::pos_fs_pol],
      s.fmt_ctl[serial_port_pkg::pos_rec_tdm],
      s.fmt_ctl[serial_port_pkg::pos_rec_sel]);
    bit_ix = 5'h1f - rslot[4:0];
    if (fall) begin
      // Master frame sync: pulse in DSP, half-frame level otherwise
      if (dsp) begin
        next_s.fs_pin = (q == 11'h000);
      end else if (fmt == serial_port_pkg::fmt_i2s) begin
        next_s.fs_pin = (q >= half) ^ fpol;
      end else begin
        next_s.fs_pin = (q < half) ^ fpol;
      end
      if (!rslot[6]) begin
        next_s.rec_bit = 1'h0;
      end else begin
        next_s.rec_bit = rslot[5] ? rr[bit_ix] : rl[bit_ix];
      end
      // In TDM the line is released outside the own slot
      next_s.rec_oe_n = hiz || (s.fmt_ctl[serial_port_pkg::pos_rec_tdm] && !rslot[6]);
    end else if (hiz) begin
      next_s.rec_oe_n = 1'h1;
    end
  end

  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '0;
      s.fmt_ctl <= serial_port_pkg::fmt_ctl_reset;
      s.div_ctl <= serial_port_pkg::div_ctl_reset;
      s.fs_ctl <= serial_port_pkg::fs_ctl_reset;
      s.flen <= serial_port_pkg::fs_ctl_reset[10:0];
      s.bclk_oe_n <= 1'h1;
      s.fs_oe_n <= 1'h1;
      s.rec_oe_n <= 1'h1;
    end else begin
      s <= next_s;
    end
  end

  // Outputs straight from the state register
  assign prdata = s.rdata;
  assign pready = s.ready;
  assign pslverr = s.err;
  assign bclk_out = s.bclk_pin;
  assign bclk_oe_n = s.bclk_oe_n;
  assign frame_sync_out = s.fs_pin;
  assign frame_sync_oe_n = s.fs_oe_n;
  assign record_serial_out = s.rec_bit;
  assign record_oe_n = s.rec_oe_n;
  assign gpio_out_clock = s.gpio_clk;
  assign record_take = s.rec_take;
  assign playback_left = s.play_l;
  assign playback_right = s.play_r;
  assign playback_valid = s.play_valid;

endmodule

// *** sim/audio_serial_port_chk.sv ***
// Checker for the audio serial port: APB answers, pin directions, pulses.
// Sees only the top module's ports; bound into every audio_serial_port.
`timescale 1ns/1ns
module audio_serial_port_chk #(
  parameter int ADDR_WIDTH = 12
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB
  input wire logic [ADDR_WIDTH-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Pin enables and pulses
  input wire logic bclk_oe_n,
  input wire logic frame_sync_oe_n,
  input wire logic record_oe_n,
  input wire logic record_take,
  input wire logic playback_valid
);
  logic [15:0] fmt_m, fs_m;
  logic wr_ok;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  assign wr_ok = psel && penable && pready && pwrite && !pslverr;
  // Mirror of the registers that steer pin directions
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fmt_m <= 16'h000a;
      fs_m <= 16'h0040;
    end else if (wr_ok && paddr == 12'h064) begin
      fmt_m <= pwdata[15:0] & 16'h3ddf;
    end else if (wr_ok && paddr == 12'h06c) begin
      fs_m <= pwdata[15:0] & 16'h0fff;
    end
  end
  property p_answer;
    psel && !penable |=> pready;
  endproperty
  a_answer: assert property (p_answer) else $error("no ready after setup");
  property p_refuse;
    psel && !penable && paddr[1:0] != 2'b00 |=> pready && pslverr;
  endproperty
  a_refuse: assert property (p_refuse) else $error("misaligned access not refused");
  property p_err_zero;
    pslverr |-> pready && prdata == 32'h0000_0000;
  endproperty
  a_err_zero: assert property (p_err_zero) else $error("refused access returned data");
  property p_hiz;
    fmt_m[8] [*4] |-> bclk_oe_n && frame_sync_oe_n && record_oe_n;
  endproperty
  a_hiz: assert property (p_hiz) else $error("pin driven while tristated");
  property p_bclk_dir;
    $stable(fmt_m) [*2] |-> bclk_oe_n == !(fmt_m[6] && !fmt_m[8]);
  endproperty
  a_bclk_dir: assert property (p_bclk_dir) else $error("bit clock enable wrong");
  property p_fs_dir;
    ($stable(fmt_m) && $stable(fs_m)) [*2] |-> frame_sync_oe_n == !(fs_m[11] && !fmt_m[8]);
  endproperty
  a_fs_dir: assert property (p_fs_dir) else $error("frame sync enable wrong");
  property p_take;
    record_take |=> !record_take;
  endproperty
  a_take: assert property (p_take) else $error("record take longer than a cycle");
  property p_valid;
    playback_valid |=> !playback_valid [*8];
  endproperty
  a_valid: assert property (p_valid) else $error("playback valid too close");
  // Main scenarios
  c_write: cover property (wr_ok && paddr == 12'h064);
  c_refuse: cover property (pslverr);
  c_frame: cover property (playback_valid);
endmodule

bind audio_serial_port audio_serial_port_chk #(.ADDR_WIDTH(ADDR_WIDTH)) chk (
  .pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready,
  .pslverr, .bclk_oe_n, .frame_sync_oe_n, .record_oe_n, .record_take, .playback_valid);

// *** sim/serial_host_model.sv ***
// Host DSP audio port: follows the device bit clock and frame sync.
// Assumes the device is master of both clocks in DSP format.
`timescale 1ns/1ns
module serial_host_model (
  // Link pins
  input wire logic bclk_pin,
  input wire logic fs_pin,
  input wire logic rec_pin,
  output logic play_bit,
  // Framing set by the bench
  input wire logic pol,
  input wire logic [5:0] off,
  input wire logic [5:0] wl,
  input wire logic [10:0] flen,
  input wire logic [31:0] tx_left,
  input wire logic [31:0] tx_right,
  // Captured record words
  output logic [31:0] rx_left,
  output logic [31:0] rx_right,
  output logic rx_done
);
  logic fs_last;
  int pos, k, j, w, o;
  initial begin
    play_bit = 1'b0;
    rx_done = 1'b0;
    rx_left = '0;
    rx_right = '0;
    fs_last = 1'b0;
    pos = 0;
  end
  // Capture on the effective rising edge; a frame starts where sync rises
  always @(posedge (bclk_pin ^ pol)) begin
    w = wl;
    o = off;
    pos = (fs_pin && !fs_last) ? 0 : pos + 1;
    fs_last = fs_pin;
    k = pos - o;
    if (pos == 0) begin
      rx_left = '0;
      rx_right = '0;
    end
    if (k >= 0 && k < w) rx_left[31-k] = rec_pin;
    else if (k >= w && k < 2 * w) rx_right[31-k+w] = rec_pin;
    rx_done = (k == 2 * w - 1);
  end
  // Present the next bit half a period early; spare slots carry noise
  always @(negedge (bclk_pin ^ pol)) begin
    w = wl;
    o = off;
    rx_done = 1'b0;
    j = ((pos == flen - 1) ? 0 : pos + 1) - o;
    if (j >= 0 && j < w) play_bit = tx_left[31-j];
    else if (j >= w && j < 2 * w) play_bit = tx_right[31-j+w];
    else play_bit = ~play_bit;
  end
endmodule

// *** sim/tb.sv ***
// Bench for the audio serial port: register checks and DSP stream loops.
// Assumes the checker and the host model are compiled before it.
`timescale 1ns/1ns
module tb;
  // Clock, reset and APB
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready, pslverr;
  // Pins, samples and host settings
  logic bclk_out, bclk_oe_n, fs_out, fs_oe_n, rec_out, rec_oe_n, play_in, valid;
  logic [31:0] rec_left = 32'h0000_0000, rec_right = 32'h0000_0000;
  logic [31:0] play_left, play_right, tx_left, tx_right, rx_left, rx_right;
  logic rx_done, pol, gpio_clk;
  logic [5:0] off, wl;
  logic [10:0] flen;
  // Expectations and tallies
  logic [32:0] reg_q[$];
  logic [63:0] play_q[$], rec_q[$];
  logic armed = 1'b0;
  int mismatches = 0, compares = 0;
  always #5 pclk = ~pclk;
  audio_serial_port #(.ADDR_WIDTH(12)) DUT (
    .pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready,
    .pslverr, .bclk_in(1'b0), .bclk_out, .bclk_oe_n, .frame_sync_in(1'b0),
    .frame_sync_out(fs_out), .frame_sync_oe_n(fs_oe_n), .playback_serial_in(play_in),
    .record_serial_out(rec_out), .record_oe_n(rec_oe_n), .gpio_out_clock(gpio_clk),
    .record_left(rec_left), .record_right(rec_right), .record_take(),
    .playback_left(play_left), .playback_right(play_right), .playback_valid(valid));
  // Released pins: clocks pulled low, record line pulled high
  serial_host_model host (
    .bclk_pin(bclk_oe_n ? 1'b0 : bclk_out), .fs_pin(fs_oe_n ? 1'b0 : fs_out),
    .rec_pin(rec_oe_n ? 1'b1 : rec_out), .play_bit(play_in), .pol, .off, .wl, .flen,
    .tx_left, .tx_right, .rx_left, .rx_right, .rx_done);
  task automatic wrap_up();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic guard(inout int n);
    @(posedge pclk);
    n++;
    if (n > 9000) begin
      $display("mismatch wait_bound expected done seen hang");
      mismatches++;
      wrap_up();
    end
  endtask
  task automatic cmp_reg(input logic [32:0] e, input logic [32:0] g);
    compares++;
    if (g !== e) begin
      mismatches++;
      $display("mismatch register expected %h seen %h", e, g);
    end
  endtask
  task automatic cmp_samp(input string s, input logic [63:0] e, input logic [63:0] g);
    compares++;
    if (g !== e) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
    int n = 0;
    @(posedge pclk);
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    psel <= 1'b1;
    @(posedge pclk);
    penable <= 1'b1;
    do guard(n); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [32:0] e);
    reg_q.push_back(e);
    apb(a, 1'b0, 32'h0000_0000);
  endtask
  // Watchers: each result that appears takes the oldest note
  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1 && !pwrite) begin
      cmp_reg(reg_q.pop_front(), {pslverr, prdata});
    end
    if (armed && valid === 1'b1 && play_q.size() > 0) begin
      cmp_samp("playback", play_q.pop_front(), {play_left, play_right});
    end
  end
  always @(posedge rx_done) begin
    if (armed && rec_q.size() > 0) begin
      cmp_samp("record", rec_q.pop_front(), {rx_left, rx_right});
    end
  end
  // Main sequence
  initial begin
    logic [31:0] d, m;
    logic gl, bl;
    int n, v, gc, bc;
    n = $urandom(58654);
    pol = 1'b0;
    off = 6'd0;
    wl = 6'd16;
    flen = 11'd40;
    tx_left = '0;
    tx_right = '0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    rd(12'h064, 33'h0_0000_000a);
    rd(12'h068, 33'h0_0000_0004);
    rd(12'h06c, 33'h0_0000_0040);
    rd(12'h066, 33'h1_0000_0000);
    rd(12'h074, 33'h1_0000_0000);
    rd(12'h070, 33'h0_0000_0040);
    $display("test reset_values done");
    d = ($urandom & 32'h0000_3ddf) | 32'h0000_0100;
    apb(12'h064, 1'b1, d);
    rd(12'h064, {1'b0, d});
    d = {20'h0, 4'($urandom_range(8)), 3'b0, 5'($urandom_range(20))};
    apb(12'h068, 1'b1, d);
    rd(12'h068, {1'b0, d});
    $display("test registers done");
    apb(12'h068, 1'b1, 32'h0000_0308);
    // Count clock rises over 64 core cycles: GPIO clock /4, bit clock /8
    repeat (16) @(posedge pclk);
    gc = 0;
    bc = 0;
    gl = gpio_clk;
    bl = bclk_out;
    repeat (64) begin
      @(posedge pclk);
      gc += int'(gpio_clk && !gl);
      bc += int'(bclk_out && !bl);
      gl = gpio_clk;
      bl = bclk_out;
    end
    cmp_samp("gpio_clock", 64'd16, 64'(gc));
    cmp_samp("bit_clock", 64'd8, 64'(bc));
    $display("test dividers done");
    for (int i = 0; i < 4; i++) begin
      wl = (i == 3) ? 6'd32 : 6'd16 + 6'(4 * i);
      pol = i[1];
      off = i[0] ? 6'd0 : 6'd1;
      flen = 11'(2 * wl + 8);
      tx_left = $urandom;
      tx_right = $urandom;
      rec_left <= $urandom;
      rec_right <= $urandom;
      apb(12'h06c, 1'b1, {20'h0, 1'b1, flen});
      apb(12'h064, 1'b1, {24'h0, pol, 2'b10, i[0], 2'(i), 2'b11});
      m = ~(32'hffff_ffff >> wl);
      n = 0;
      v = 0;
      while (v < 3) begin
        guard(n);
        v += int'(valid === 1'b1);
      end
      play_q.push_back({tx_left & m, tx_right & m});
      rec_q.push_back({rec_left & m, rec_right & m});
      armed <= 1'b1;
      while (play_q.size() + rec_q.size() > 0) guard(n);
      armed <= 1'b0;
      $display("test stream %0d done", i);
    end
    // Master frame length is the programmed rate, frame locked
    rd(12'h070, 33'h0_0000_1048);
    $display("test status done");
    wrap_up();
  end
endmodule
